/* File: core/hlt_defs.svh */
// Constants for the hardware limit timer mode block.
// Overview of operation
// - Mode bits [4:3] pick class: 00 period, 01 one-shot, 10 monostable, 11 reserved.
// - In debug mode all external trigger and reset inputs are ignored.
// - Modes 011/100/101 run with enable, reset on any, rising, falling edge.
// - Modes 110/111 hold counter reset while signal is low or high.
// - One-shot 000 starts on enable alone and ends after period match.
// - One-shot 001/010/011 start on rising, falling, any edge; no external reset.
// - One-shot 100/101 start on first edge, later same edges reset count.
// - One-shot 110/111 start on rising/falling edge, held reset on low/high level.
// - Monostable 001/010/011 start on edge, stop after match or enable clear.
// - Edge-start modes need a fresh edge after re-enabling to resume.
// - One-shot match: next clock clears enable and stops counter at zero.
// - Monostable 001/010/011 match: next clock stops at zero, enable stays set; monostable 110/111 clear enable as one-shot does.
// - Count compared with period each clock; match clears count next clock.
// - Postscaler reaching selection gives a one-clock pulse and clears, in the period class only.
`ifndef HLT_DEFS_SVH
`define HLT_DEFS_SVH
`define HLT_ADR_CTRL     4'h0
`define HLT_ADR_MODE     4'h1
`define HLT_ADR_PERIOD   4'h2
`define HLT_ADR_COUNT    4'h3
`define HLT_ADR_STATUS   4'h4
`define HLT_CTRL_ON      0
`define HLT_CTRL_DEBUG   1
`define HLT_PERIOD_RST   8'hFF
`define HLT_CLS_PERIOD   2'h0
`define HLT_CLS_ONESHOT  2'h1
`define HLT_CLS_MONO     2'h2
`define HLT_EDGE_GAP     6
`define HLT_LEVEL_MIN    3
`endif

/* File: core/hlt_pkg.sv */
// Types shared by the hardware limit timer block.
package hlt_pkg;
    typedef struct packed {
        logic [4:0] mode;
        logic [3:0] postscale_select;
        logic       on;
        logic       debug;
    } hlt_ctrl_s;
    typedef enum logic [1:0] {HLT_IDLE, HLT_ARMED, HLT_RUN} hlt_state_e;
endpackage

/* File: core/hlt_timer.sv */
// Hardware limit timer with mode control and a classic Wishbone slave.
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "hlt_defs.svh"
module hlt_timer #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             external_reset_signal,
    output logic                  postscaled_pulse_out
);
    if (WIDTH < 2 || WIDTH > 24)
    begin
        $error("WIDTH out of range");
    end

    hlt_pkg::hlt_ctrl_s         ctrl;
    hlt_pkg::hlt_state_e        state;
    logic [WIDTH-1:0]           count_register;
    logic [WIDTH-1:0]           period_register;
    logic [3:0]                 post_cnt;
    logic                       ers_meta;
    logic                       ers_sync;
    logic                       ers_prev;
    logic                       match_seen;

    // Bus decode.
    wire        bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
    wire        wr_ctrl  = bus_wr && wb_adr_i == `HLT_ADR_CTRL;
    wire        wr_mode  = bus_wr && wb_adr_i == `HLT_ADR_MODE;
    wire        wr_per   = bus_wr && wb_adr_i == `HLT_ADR_PERIOD;
    wire        wr_cnt   = bus_wr && wb_adr_i == `HLT_ADR_COUNT;

    // External input, ignored in debug mode.
    wire        ers      = ctrl.debug ? 1'b0 : ers_sync;
    wire        ers_rise = !ctrl.debug && ers_sync && !ers_prev;
    wire        ers_fall = !ctrl.debug && !ers_sync && ers_prev;
    wire [1:0]  cls      = ctrl.mode[4:3];
    wire [2:0]  sub      = ctrl.mode[2:0];

    function automatic logic edge_pick(input logic [1:0] kind,
                                       input logic r, input logic f);
        case (kind)
            2'h1:    edge_pick = r;
            2'h2:    edge_pick = f;
            2'h3:    edge_pick = r | f;
            default: edge_pick = 1'b0;
        endcase
    endfunction

    // Start edge per sub-mode; 100/110 rising, 101/111 falling.
    wire [1:0]  start_kind = sub[2] ? {sub[0], !sub[0]} : sub[1:0];
    wire        start_edge = edge_pick(start_kind, ers_rise, ers_fall);

    logic run_ok;
    logic hold_rst;
    logic ext_rst;
    logic need_edge;
    always_comb
    begin
        run_ok    = 1'b1;
        hold_rst  = 1'b0;
        ext_rst   = 1'b0;
        need_edge = 1'b0;
        case (cls)
            `HLT_CLS_PERIOD:
            begin
                case (sub)
                    3'h1: run_ok = ers;
                    3'h2: run_ok = !ers;
                    3'h3: ext_rst = ers_rise | ers_fall;
                    3'h4: ext_rst = ers_rise;
                    3'h5: ext_rst = ers_fall;
                    3'h6: hold_rst = !ers;
                    3'h7: hold_rst = ers;
                    default: run_ok = 1'b1;
                endcase
            end
            `HLT_CLS_ONESHOT:
            begin
                need_edge = sub != 3'h0;
                case (sub)
                    3'h4: ext_rst = ers_rise;
                    3'h5: ext_rst = ers_fall;
                    3'h6: hold_rst = !ers;
                    3'h7: hold_rst = ers;
                    default: ext_rst = 1'b0;
                endcase
            end
            `HLT_CLS_MONO:
            begin
                case (sub)
                    3'h1, 3'h2, 3'h3: need_edge = 1'b1;
                    3'h6: hold_rst = !ers;
                    3'h7: hold_rst = ers;
                    default: run_ok = 1'b0;
                endcase
                if (sub == 3'h6 || sub == 3'h7)
                begin
                    run_ok = sub[0] ? !ers : ers;
                end
            end
            default: run_ok = 1'b0;
        endcase
        if (ctrl.debug)
        begin
            hold_rst = 1'b0;
        end
    end

    wire        one_shot = cls == `HLT_CLS_ONESHOT ||
                           (cls == `HLT_CLS_MONO && sub[2:1] == 2'h3);
    wire        mono     = cls == `HLT_CLS_MONO && !sub[2];
    wire        is_match = count_register == period_register;
    wire        counting = state == hlt_pkg::HLT_RUN && ctrl.on &&
                           run_ok && !hold_rst;
    wire        match_now = counting && is_match;
    wire        clr_cnt  = match_now || hold_rst || ext_rst || wr_cnt;
    wire        post_hit = match_seen && !one_shot && !mono &&
                           post_cnt == ctrl.postscale_select;
    wire        ps_clear = wr_cnt || wr_ctrl || ext_rst || post_hit;

    hlt_pkg::hlt_state_e next_state;
    always_comb
    begin
        next_state = state;
        case (state)
            hlt_pkg::HLT_IDLE:
                if (ctrl.on)
                begin
                    next_state = need_edge ? hlt_pkg::HLT_ARMED
                                           : hlt_pkg::HLT_RUN;
                end
            hlt_pkg::HLT_ARMED:
                if (!ctrl.on)
                begin
                    next_state = hlt_pkg::HLT_IDLE;
                end
                else if (start_edge)
                begin
                    next_state = hlt_pkg::HLT_RUN;
                end
            hlt_pkg::HLT_RUN:
                if (!ctrl.on)
                begin
                    next_state = hlt_pkg::HLT_IDLE;
                end
                else if (match_now && (one_shot || mono))
                begin
                    next_state = one_shot ? hlt_pkg::HLT_IDLE
                                          : hlt_pkg::HLT_ARMED;
                end
            default: next_state = hlt_pkg::HLT_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ers_meta <= 1'b0;
            ers_sync <= 1'b0;
            ers_prev <= 1'b0;
        end
        else
        begin
            ers_meta <= external_reset_signal;
            ers_sync <= ers_meta;
            ers_prev <= ers_sync;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state          <= hlt_pkg::HLT_IDLE;
            count_register <= '0;
            match_seen     <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            match_seen     <= match_now;
            if (wr_cnt)
            begin
                count_register <= wb_dat_i[WIDTH-1:0];
            end
            else if (clr_cnt)
            begin
                count_register <= '0;
            end
            else if (counting)
            begin
                count_register <= count_register + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            post_cnt             <= '0;
            postscaled_pulse_out <= 1'b0;
        end
        else
        begin
            postscaled_pulse_out <= post_hit;
            if (ps_clear)
            begin
                post_cnt <= '0;
            end
            else if (match_seen)
            begin
                post_cnt <= post_cnt + 4'h1;
            end
        end
    end

    // Control register; a bus write wins over the hardware clear of enable at a one-shot match.
    wire clr_on = match_now && one_shot;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl            <= '0;
            period_register <= {WIDTH{1'b1}};
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl.on    <= wb_dat_i[`HLT_CTRL_ON];
                ctrl.debug <= wb_dat_i[`HLT_CTRL_DEBUG];
                ctrl.postscale_select <= wb_dat_i[7:4];
            end
            else if (clr_on)
            begin
                ctrl.on <= 1'b0;
            end
            if (wr_mode)
            begin
                ctrl.mode <= wb_dat_i[4:0];
            end
            if (wr_per)
            begin
                period_register <= wb_dat_i[WIDTH-1:0];
            end
        end
    end

    logic [31:0] rd_mux;
    always_comb
    begin
        case (wb_adr_i)
            `HLT_ADR_CTRL:   rd_mux = {24'h0, ctrl.postscale_select, 2'h0,
                                       ctrl.debug, ctrl.on};
            `HLT_ADR_MODE:   rd_mux = {27'h0, ctrl.mode};
            `HLT_ADR_PERIOD: rd_mux = 32'(period_register);
            `HLT_ADR_COUNT:  rd_mux = 32'(count_register);
            `HLT_ADR_STATUS: rd_mux = {30'h0, state};
            default:         rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd_mux;
        end
    end

    a_match_clears: assert property (@(posedge core_clk) disable iff (!rstn)
        counting && is_match && !wr_cnt |=> count_register == '0)
        else $error("count not cleared after match");
    a_oneshot_off: assert property (@(posedge core_clk) disable iff (!rstn)
        clr_on && !wr_ctrl |=> !ctrl.on)
        else $error("enable not cleared in one-shot");
    a_mono_keep_on: assert property (@(posedge core_clk) disable iff (!rstn)
        match_now && mono && !wr_ctrl |=> ctrl.on)
        else $error("monostable lost enable");
    a_debug_ignore: assert property (@(posedge core_clk) disable iff (!rstn)
        ctrl.debug |-> !ext_rst && !start_edge && !hold_rst)
        else $error("external input acted in debug");
    a_gate_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        cls == 2'h0 && sub == 3'h1 && !ers && !clr_cnt && !wr_mode
        |=> $stable(count_register))
        else $error("gate did not stop counter");
    a_level_rst: assert property (@(posedge core_clk) disable iff (!rstn)
        cls == 2'h0 && sub == 3'h7 && ers && !wr_cnt
        |=> count_register == '0)
        else $error("level reset not held");
    a_edge_rst: assert property (@(posedge core_clk) disable iff (!rstn)
        cls == 2'h0 && sub == 3'h4 && ers_rise && !wr_cnt
        |=> count_register == '0)
        else $error("edge reset missed");
    a_post_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        postscaled_pulse_out && ctrl.postscale_select != 4'h0
        |=> !postscaled_pulse_out)
        else $error("postscaled pulse too long");
    a_armed_wait: assert property (@(posedge core_clk) disable iff (!rstn)
        state == hlt_pkg::HLT_ARMED && !start_edge && ctrl.on
        |=> state != hlt_pkg::HLT_RUN)
        else $error("started without edge");
    a_reserved_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        cls == 2'h3 && !wr_cnt |=> $stable(count_register))
        else $error("counted in reserved class");
endmodule
`default_nettype wire

/* File: tb/hlt_ers_src.sv */
// Model of the external trigger source that keeps its edges spaced.
`timescale 1ns/1ns
`default_nettype none
module hlt_ers_src (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic want,
    output logic      ers
);
    logic [3:0] since;
    wire        may_move = (since >= 4'h6);
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ers   <= 1'b0;
            since <= 4'hF;
        end
        else if (want != ers && may_move)
        begin
            ers   <= want;
            since <= 4'h1;
        end
        else if (since != 4'hF)
            since <= since + 4'h1;
    end
endmodule
`default_nettype wire

/* File: tb/hardware_limit_timer_modes_tb.sv */
// Self-checking bench for the hardware limit timer.
`timescale 1ns/1ns
`default_nettype none
`include "hlt_defs.svh"
module hardware_limit_timer_modes_tb;
    logic        core_clk;
    logic        rstn;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [3:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        want;
    logic        ers;
    logic        pulse;
    logic [31:0] rd;
    logic [31:0] rd2;
    int          errors;
    int          cmp_count;
    int          cycles;

    hlt_timer dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .external_reset_signal(ers),
        .postscaled_pulse_out(pulse));
    hlt_ers_src src (.core_clk(core_clk), .rstn(rstn), .want(want),
        .ers(ers));

    always #20 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One classic cycle; entered just after a rising edge.
    task automatic wb(input logic we, input logic [3:0] adr,
                      input logic [31:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge core_clk);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Stops the timer, then sets mode and period and clears the count.
    task automatic setup(input logic [31:0] mode, input logic [31:0] per);
        wb(1'b1, `HLT_ADR_CTRL, 32'h00);
        wb(1'b1, `HLT_ADR_MODE, mode);
        wb(1'b1, `HLT_ADR_PERIOD, per);
        wb(1'b1, `HLT_ADR_COUNT, 32'h00);
    endtask

    task automatic t_reset;
        wb(1'b0, `HLT_ADR_PERIOD, 32'h0);
        check(rd, 32'hFF);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(rd, 32'h00);
        wb(1'b1, 4'hF, 32'h5A);
        wb(1'b0, 4'hF, 32'h0);
        check(rd, 32'h00);
        setup(32'h18, 32'hC8);
        wb(1'b1, `HLT_ADR_CTRL, 32'h01);
        idle(20);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(rd, 32'h00);
        $display("test reset done");
    endtask

    task automatic t_gate;
        setup(32'h00, 32'hC8);
        wb(1'b1, `HLT_ADR_CTRL, 32'h01);
        idle(10);
        wb(1'b1, `HLT_ADR_CTRL, 32'h00);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        rd2 = rd;
        check(32'(rd2 != 32'h0), 32'h1);
        idle(10);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(rd, rd2);
        setup(32'h01, 32'hC8);
        wb(1'b1, `HLT_ADR_CTRL, 32'h01);
        idle(20);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(rd, 32'h00);
        $display("test gate done");
    endtask

    task automatic t_edge_reset;
        setup(32'h04, 32'hC8);
        wb(1'b1, `HLT_ADR_CTRL, 32'h01);
        idle(40);
        want <= 1'b1;
        idle(10);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(32'(rd < 32'h14), 32'h1);
        $display("test edge reset done");
    endtask

    task automatic t_level;
        setup(32'h07, 32'hC8);
        wb(1'b1, `HLT_ADR_CTRL, 32'h01);
        idle(20);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(rd, 32'h00);
        wb(1'b1, `HLT_ADR_CTRL, 32'h03);
        idle(20);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(32'(rd != 32'h0), 32'h1);
        $display("test level done");
    endtask

    task automatic t_oneshot;
        setup(32'h08, 32'h04);
        wb(1'b1, `HLT_ADR_CTRL, 32'h01);
        idle(30);
        wb(1'b0, `HLT_ADR_CTRL, 32'h0);
        check(rd & 32'h1, 32'h0);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(rd, 32'h00);
        $display("test one-shot done");
    endtask

    task automatic t_mono;
        want <= 1'b0;
        setup(32'h11, 32'h04);
        wb(1'b1, `HLT_ADR_CTRL, 32'h01);
        idle(10);
        wb(1'b0, `HLT_ADR_STATUS, 32'h0);
        check(rd & 32'h3, 32'h1);
        want <= 1'b1;
        idle(30);
        wb(1'b0, `HLT_ADR_COUNT, 32'h0);
        check(rd, 32'h00);
        wb(1'b0, `HLT_ADR_CTRL, 32'h0);
        check(rd & 32'h1, 32'h1);
        $display("test monostable done");
    endtask

    task automatic t_post;
        int n;
        n = 0;
        setup(32'h00, 32'h02);
        wb(1'b1, `HLT_ADR_CTRL, 32'h11);
        idle(20);
        repeat (60)
        begin
            @(posedge core_clk);
            n += int'(pulse === 1'b1);
        end
        check(32'(n), 32'd10);
        $display("test postscaler done");
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end

    initial
    begin
        core_clk = 1'b0;
        rstn = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        want = 1'b0;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        idle(8);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_gate();
        t_edge_reset();
        t_level();
        t_oneshot();
        t_mono();
        t_post();
        end_of_test();
    end
endmodule
`default_nettype wire
